// >>> core/mcpu_reg.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// small registered word store with reset value
// ----------------------------------------
module mcpu_reg #(
    parameter W = 16
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         we,
    input  wire [W-1:0] wdata,
    output reg  [W-1:0] q
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= {W{1'b0}};
        end else if (we) begin
            q <= wdata;
        end
    end
endmodule
`default_nettype wire

// >>> core/mcpu_unit.v
// Notes on behaviour
// - sixteen-bit pattern output bus drives up to sixteen timer slices
// - enabled set request from software or hardware input arms trigger flag
// - software select bit picks software; else one of eight inputs, chosen edge
// - one of four sync inputs chosen; its falling edge is sync event
// - sync edge with trigger set copies shadow into pattern output register
// - stand-alone: sync event clears trigger flag; software may clear it too
// - update request output equals trigger flag, ends after pattern update
// - hall mode: set request arms only alongside a correct hall event
// - hall mode: done output asserts on sync event, clearing means done
// - stand-alone: software may clear pattern output register any time (here an update in the same cycle wins over the clear)
// - hall mode: pattern cleared by software or by hardware idle
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mcpu_consts.vh"
module mcpu_unit #(
    parameter PAT_W = 16,
    parameter NSET  = 8,
    parameter NSYNC = 4
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output wire             pready,
    output wire             pslverr,
    input  wire [NSET-1:0]  set_request_inputs,
    input  wire [NSYNC-1:0] sync_inputs,
    input  wire             hall_correct_event,
    input  wire             hall_idle,
    output wire [PAT_W-1:0] pattern_outputs,
    output wire             update_request_out,
    output reg              update_done_out,
    output wire             irq
);
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    reg  [`MCPU_CFG_W-1:0] config_reg;
    reg  [`MCPU_IRQ_W-1:0] irq_stat;
    reg  [`MCPU_IRQ_W-1:0] irq_mask;
    reg                    update_trigger_flag;
    reg  [PAT_W-1:0]       pattern;
    reg  [NSET-1:0]        set_prev;
    reg  [NSYNC-1:0]       sync_prev;
    wire [PAT_W-1:0]       shadow_pattern;

    wire       sw_update_select  = config_reg[`MCPU_CFG_SW_SEL];
    wire [2:0] set_input_select  = config_reg[`MCPU_CFG_SET_HI:`MCPU_CFG_SET_LO];
    wire [1:0] set_edge_select   = config_reg[`MCPU_CFG_EDGE_HI:`MCPU_CFG_EDGE_LO];
    wire [1:0] sync_input_select = config_reg[`MCPU_CFG_SYNC_HI:`MCPU_CFG_SYNC_LO];
    wire       hall_mode         = config_reg[`MCPU_CFG_HALL];
    wire       set_enable        = config_reg[`MCPU_CFG_EN];

    // shadow held in the small store; no side effect on write
    mcpu_reg #(.W(PAT_W)) u_shadow (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (wr & hit(paddr, `MCPU_OFF_SHADOW)),
        .wdata   (pwdata[PAT_W-1:0]),
        .q       (shadow_pattern)
    );

    // ----------------------------------------
    // set request source and edge
    // ----------------------------------------
    wire cmd_wr    = wr & hit(paddr, `MCPU_OFF_COMMAND);
    wire sw_set    = cmd_wr & pwdata[`MCPU_CMD_SET];
    wire sw_clr    = cmd_wr & pwdata[`MCPU_CMD_CLR_TRIG];
    wire sw_clrpat = cmd_wr & pwdata[`MCPU_CMD_CLR_PAT];
    wire set_now   = set_request_inputs[set_input_select];
    wire set_was   = set_prev[set_input_select];
    reg  hw_set;
    always @* begin
        case (set_edge_select)
            `MCPU_EDGE_RISE: hw_set = set_now & ~set_was;
            `MCPU_EDGE_FALL: hw_set = ~set_now & set_was;
            `MCPU_EDGE_BOTH: hw_set = set_now ^ set_was;
            default:         hw_set = 1'b0;
        endcase
    end
    wire set_req = set_enable & (sw_update_select ? sw_set : hw_set);
    // hall mode needs the correct hall event in the same cycle
    wire arm = set_req & (~hall_mode | hall_correct_event);

    // ----------------------------------------
    // sync falling edge
    // ----------------------------------------
    wire sync_ev = ~sync_inputs[sync_input_select] & sync_prev[sync_input_select];
    wire update  = sync_ev & update_trigger_flag;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_prev  <= {NSET{1'b0}};
            sync_prev <= {NSYNC{1'b0}};
        end else begin
            set_prev  <= set_request_inputs;
            sync_prev <= sync_inputs;
        end
    end

    // ----------------------------------------
    // trigger flag, pattern, done
    // ----------------------------------------
    // arming wins over a clear in the same cycle, so no request is lost
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            update_trigger_flag <= 1'b0;
        end else if (arm) begin
            update_trigger_flag <= 1'b1;
        end else if (update | sw_clr) begin
            update_trigger_flag <= 1'b0;
        end
    end
    assign update_request_out = update_trigger_flag;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern <= {PAT_W{1'b0}};
        end else if (update) begin
            pattern <= shadow_pattern;
        end else if (sw_clrpat | (hall_mode & hall_idle)) begin
            pattern <= {PAT_W{1'b0}};
        end
    end
    assign pattern_outputs = pattern;

    // one cycle high after an update in hall mode only; its fall marks done
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            update_done_out <= 1'b0;
        end else begin
            update_done_out <= update & hall_mode;
        end
    end

    // ----------------------------------------
    // config and interrupts
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= `MCPU_CFG_RESET;
            irq_mask   <= {`MCPU_IRQ_W{1'b0}};
        end else begin
            if (wr & hit(paddr, `MCPU_OFF_CONFIG)) begin
                config_reg <= pwdata[`MCPU_CFG_W-1:0];
            end
            if (wr & hit(paddr, `MCPU_OFF_IRQ_MASK)) begin
                irq_mask <= pwdata[`MCPU_IRQ_W-1:0];
            end
        end
    end

    wire [`MCPU_IRQ_W-1:0] irq_ev = {set_req & ~arm, update, arm};
    wire irq_rd = rd & hit(paddr, `MCPU_OFF_IRQ_STAT);
    // read clears, but an event in the same cycle stays set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= {`MCPU_IRQ_W{1'b0}};
        end else begin
            irq_stat <= (irq_rd ? {`MCPU_IRQ_W{1'b0}} : irq_stat) | irq_ev;
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always @* begin
        prdata = 32'h00000000;
        case (paddr)
            `MCPU_OFF_CONFIG:   prdata[`MCPU_CFG_W-1:0] = config_reg;
            `MCPU_OFF_SHADOW:   prdata[PAT_W-1:0]       = shadow_pattern;
            `MCPU_OFF_STATUS:   prdata[1:0] = {update_done_out, update_trigger_flag};
            `MCPU_OFF_PATTERN:  prdata[PAT_W-1:0]       = pattern;
            `MCPU_OFF_IRQ_STAT: prdata[`MCPU_IRQ_W-1:0] = irq_stat;
            `MCPU_OFF_IRQ_MASK: prdata[`MCPU_IRQ_W-1:0] = irq_mask;
            default:            prdata = 32'h00000000;
        endcase
    end
endmodule
`default_nettype wire

// >>> shared/mcpu_consts.vh
`ifndef MCPU_CONSTS_VH
`define MCPU_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MCPU_OFF_CONFIG   12'h000
`define MCPU_OFF_SHADOW   12'h004
`define MCPU_OFF_COMMAND  12'h008
`define MCPU_OFF_STATUS   12'h00C
`define MCPU_OFF_PATTERN  12'h010
`define MCPU_OFF_IRQ_STAT 12'h014
`define MCPU_OFF_IRQ_MASK 12'h018
// ----------------------------------------
// config fields
// ----------------------------------------
`define MCPU_CFG_SW_SEL   0
`define MCPU_CFG_SET_LO   1
`define MCPU_CFG_SET_HI   3
`define MCPU_CFG_EDGE_LO  4
`define MCPU_CFG_EDGE_HI  5
`define MCPU_CFG_SYNC_LO  6
`define MCPU_CFG_SYNC_HI  7
`define MCPU_CFG_HALL     8
`define MCPU_CFG_EN       9
`define MCPU_CFG_W        10
`define MCPU_CFG_RESET    10'h000
// ----------------------------------------
// command bits (write one, self clearing)
// ----------------------------------------
`define MCPU_CMD_SET      0
`define MCPU_CMD_CLR_TRIG 1
`define MCPU_CMD_CLR_PAT  2
// ----------------------------------------
// edge select codes
// ----------------------------------------
`define MCPU_EDGE_NONE    2'h0
`define MCPU_EDGE_RISE    2'h1
`define MCPU_EDGE_FALL    2'h2
`define MCPU_EDGE_BOTH    2'h3
// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define MCPU_IRQ_ARMED    0
`define MCPU_IRQ_UPDATE   1
`define MCPU_IRQ_DROPPED  2
`define MCPU_IRQ_W        3
`endif

// >>> testbench/mcpu_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mcpu_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [7:0]  set_request_inputs,
    input wire logic [3:0]  sync_inputs,
    input wire logic        hall_correct_event,
    input wire logic        hall_idle,
    input wire logic [15:0] pattern_outputs,
    input wire logic        update_request_out,
    input wire logic        update_done_out
);
    // ----
    // snooped config and shadow, previous input samples
    // ----
    logic [9:0]  cfg;
    logic [15:0] shd;
    logic [7:0]  sd;
    logic [3:0]  yd;
    wire wr = psel && penable && pwrite;
    wire cmd = wr && paddr == 12'h008;
    wire sf = yd[cfg[7:6]] && !sync_inputs[cfg[7:6]];
    wire rs = !sd[cfg[3:1]] && set_request_inputs[cfg[3:1]];
    wire fs = sd[cfg[3:1]] && !set_request_inputs[cfg[3:1]];
    wire hw = !cfg[0] && cfg[9] && ((rs && cfg[4]) || (fs && cfg[5]));
    // arming wins over clearing, so exclude every arming cause
    wire quiet = !wr && !hall_idle && sd == set_request_inputs;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 10'h000;
            shd <= 16'h0000;
            sd <= 8'h00;
            yd <= 4'h0;
        end else begin
            sd <= set_request_inputs;
            yd <= sync_inputs;
            if (wr && paddr == 12'h000) cfg <= pwdata[9:0];
            if (wr && paddr == 12'h004) shd <= pwdata[15:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_fire; update_request_out && sf && quiet; endsequence
    property p_copy; s_fire |=> pattern_outputs == shd; endproperty
    a_copy: assert property (p_copy) else $error("pattern not copied");
    property p_clear; s_fire |=> !update_request_out; endproperty
    a_clear: assert property (p_clear) else $error("flag kept");
    property p_hold; !update_request_out && quiet |=> $stable(pattern_outputs)
        && !update_request_out; endproperty
    a_hold: assert property (p_hold) else $error("idle change");
    property p_sw; cmd && pwdata[0] && cfg[0] && cfg[9] && !cfg[8] |=> update_request_out;
    endproperty
    a_sw: assert property (p_sw) else $error("sw set lost");
    property p_hw; hw && !cfg[8] |=> update_request_out; endproperty
    a_hw: assert property (p_hw) else $error("hw set lost");
    property p_hall; $rose(update_request_out) && cfg[8] |-> $past(hall_correct_event); endproperty
    a_hall: assert property (p_hall) else $error("armed without hall");
    property p_en; $rose(update_request_out) |-> $past(cfg[9]); endproperty
    a_en: assert property (p_en) else $error("armed while off");
    property p_done; update_done_out |-> cfg[8] ##1 !update_done_out; endproperty
    a_done: assert property (p_done) else $error("bad done pulse");
    property p_idle; cfg[8] && hall_idle && !update_request_out |=> pattern_outputs == 16'h0000;
    endproperty
    a_idle: assert property (p_idle) else $error("idle kept pattern");
    property p_clrp; cmd && pwdata[2] && !update_request_out |=> pattern_outputs == 16'h0000;
    endproperty
    a_clrp: assert property (p_clrp) else $error("pattern not cleared");
endmodule
bind mcpu_unit mcpu_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .set_request_inputs, .sync_inputs, .hall_correct_event, .hall_idle, .pattern_outputs,
    .update_request_out, .update_done_out);
`default_nettype wire

// >>> testbench/mcpu_slice_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcpu_slice_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] slice_pattern_input,
    input  wire logic        pattern_set_request,
    input  wire logic [15:0] slice_multichannel_enable,
    input  wire logic [15:0] slice_shadow_transfer_enable,
    input  wire logic        slice_compare_status,
    output logic      [15:0] slice_output
);
    logic [1:0] hold;
    logic       req_d;
    // status stretched so the new pattern still meets a valid status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= 2'h0;
            req_d <= 1'b0;
        end else begin
            req_d <= pattern_set_request;
            if (pattern_set_request && !req_d) hold <= 2'h3;
            else if (hold != 2'h0) hold <= hold - 2'h1;
        end
    end
    wire        st = slice_compare_status || hold != 2'h0;
    wire [15:0] gate = slice_multichannel_enable & slice_shadow_transfer_enable;
    assign slice_output = {16{st}} & (~gate | slice_pattern_input);
endmodule
`default_nettype wire

// >>> testbench/test_multichannel_pattern_update.sv
`timescale 1ns/1ps
`default_nettype none
module test_multichannel_pattern_update;
    logic        pclk, presetn, psel, penable, pwrite, hce, hidle, cst;
    logic [11:0] paddr;
    logic [31:0] pwdata, pr_q, d;
    logic [7:0]  set_in;
    logic [3:0]  sync;
    wire  [31:0] prdata;
    wire         pready, pslverr, upd, done, irq;
    wire  [15:0] pat, sout;
    int          n_fail, tests_run, cyc, k;
    mcpu_unit uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .set_request_inputs(set_in), .sync_inputs(sync),
        .hall_correct_event(hce), .hall_idle(hidle), .pattern_outputs(pat),
        .update_request_out(upd), .update_done_out(done), .irq);
    mcpu_slice_model slices (.pclk, .presetn, .slice_pattern_input(pat),
        .pattern_set_request(upd), .slice_multichannel_enable(16'hFFFF),
        .slice_shadow_transfer_enable(16'hFFFF), .slice_compare_status(cst),
        .slice_output(sout));
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // read data taken at the access edge, before read-clear lands
    always @(posedge pclk) pr_q <= prdata;
    always @(posedge pclk) if (++cyc == 4000) begin n_fail++; test_done; end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= v;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
        #1 d = pr_q;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", n, e, g);
            n_fail++;
        end
    endtask
    task automatic wt(input int c); repeat (c) @(posedge pclk); #1; endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, set_in, sync, hce, hidle} = '0;
        cst = 1; presetn = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h00C, 0); chk("status", 0, d);
        apb(1, 12'h004, 32'hA5C3);
        apb(1, 12'h000, 32'h281);
        apb(1, 12'h008, 1); chk("req", 1, upd);
        @(posedge pclk) sync <= 4'h6;
        @(posedge pclk) sync <= 4'h4; wt(2);
        chk("unsel_sync", 0, pat);
        @(posedge pclk) sync <= 4'h0; wt(2);
        chk("pat", 16'hA5C3, pat);
        chk("req_end", 0, upd);
        chk("slices", 16'hA5C3, sout);
        apb(1, 12'h004, 32'h1234);
        @(posedge pclk) sync <= 4'h4;
        @(posedge pclk) sync <= 4'h0; wt(2);
        chk("pat_keep", 16'hA5C3, pat);
        apb(1, 12'h008, 1); apb(1, 12'h008, 2); chk("sw_clr", 0, upd);
        apb(1, 12'h008, 4); apb(0, 12'h010, 0); chk("pat_clr", 0, d);
        for (int e = 0; e < 4; e++) begin
            apb(1, 12'h000, 32'h28A | (e << 4));
            @(posedge pclk) set_in <= 8'h20; wt(2);
            chk("hw_rise", e[0], upd);
            @(posedge pclk) set_in <= 8'h00; wt(2);
            chk("hw_fall", e != 0, upd);
            apb(1, 12'h008, 2);
        end
        apb(1, 12'h004, 32'h00F0);
        apb(1, 12'h000, 32'h381);
        apb(1, 12'h008, 1); chk("hall_drop", 0, upd);
        @(posedge pclk) hce <= 1;
        apb(1, 12'h008, 1); chk("hall_arm", 1, upd);
        @(posedge pclk) hce <= 0;
        @(posedge pclk) sync <= 4'h4;
        @(posedge pclk) sync <= 4'h0;
        k = 0;
        repeat (4) begin @(posedge pclk); #1 k += done; end
        chk("done_len", 1, k);
        chk("hall_pat", 16'h00F0, pat);
        @(posedge pclk) hidle <= 1; wt(2);
        chk("idle", 0, pat);
        @(posedge pclk) hidle <= 0;
        chk("irq_masked", 0, irq);
        apb(1, 12'h018, 7); chk("irq", 1, irq);
        apb(0, 12'h014, 0); chk("irq_stat", 7, d);
        chk("irq_clr", 0, irq);
        apb(0, 12'h0FC, 0); chk("unmapped", 0, d);
        test_done;
    end
endmodule
`default_nettype wire
